// ==== src/cps_defines.vh ====
/*
 * Constants for the capture precondition block: register word offsets,
 * reset values, setting limits, codes and timing.
 * Assumes a 16-bit word-addressed register port.
 */
`ifndef CPS_DEFINES_VH
`define CPS_DEFINES_VH

// Register word offsets
`define CPS_POS_CH0 8'h40
`define CPS_EDGE_CH0 8'h44
`define CPS_FILT_CH0 8'h46
`define CPS_SRC_CH0 8'h48
`define CPS_POS_CH1 8'h5A
`define CPS_EDGE_CH1 8'h5E
`define CPS_FILT_CH1 8'h60
`define CPS_SRC_CH1 8'h62

// Reset values
`define CPS_EDGE_RST 8'h01
`define CPS_FILT_RST 8'h00
`define CPS_SRC_RST 8'h00

// Setting limits
`define CPS_EDGE_MIN 8'h01
`define CPS_EDGE_MAX 8'h03
`define CPS_FILT_MAX 8'h02
`define CPS_SRC_MAX 8'h0B

// Edge codes
`define CPS_EDGE_RISE 8'h01
`define CPS_EDGE_FALL 8'h02
`define CPS_EDGE_BOTH 8'h03

// Event modes
`define CPS_EV_IGNORE 2'h0
`define CPS_EV_AFTER 2'h1
`define CPS_EV_HIGH 2'h2
`define CPS_EV_LOW 2'h3

// Source codes
`define CPS_SRC_NONE 8'h0B
`define CPS_NUM_SRC 12

// Unit code that reads in 16-bit counts
`define CPS_UNIT_CNT16 8'h04

// Logic tick and clock period in ns
`define CPS_TICK_NS 40
`define CPS_CLK_NS 5

`endif

// ==== src/cps_capture_precondition_select.v ====
/*
 * Two position capture channels with precondition selection and edge
 * qualification, plus the 16-bit word register port.
 * Assumes position_counts and all mode inputs are on ref_clk; the
 * capture source pins are asynchronous and are synchronised here.
 */
// Function
// (RULE1) Captured position signed 64-bit, reset zero
// (RULE2) Captured position read in configured units
// (RULE3) Edge codes: 1 rise, 2 fall, 3 both
// (RULE4) Edge setting 8-bit, 1..3, resets rising
// (RULE5) Trigger always edge; precondition edge optional
// (RULE6) Trigger has own matching edge selector
// (RULE7) Filter accepts 0..2, resets 0, no effect
// (RULE8) Source codes map inputs, differentials, index
// (RULE9) Source 8-bit, 0..11, reset 0
// (RULE10) Event modes 0..3 qualify trigger
// (RULE11) Trigger in same tick as precondition ignored
// (RULE12) Edge compares sample with previous cycle
`include "cps_defines.vh"
`default_nettype none

module cps_channel #(
    parameter HOLD_CYC = 8
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [`CPS_NUM_SRC-1:0] sources,
    input wire [7:0] pre_source,
    input wire [7:0] pre_edge,
    input wire [7:0] trigger_source,
    input wire [7:0] trigger_edge_select,
    input wire [1:0] event_mode_select,
    input wire capture_enable,
    input wire [63:0] position_units,
    output reg [63:0] captured_position,
    output reg capture_event
);
    reg [`CPS_NUM_SRC-1:0] prev;
    reg armed;
    reg [7:0] hold;
    reg [7:0] next_hold;
    wire [`CPS_NUM_SRC-1:0] rise = sources & ~prev;
    wire [`CPS_NUM_SRC-1:0] fall = ~sources & prev;
    wire pre_level;
    wire pre_hit;
    wire trig_hit;
    wire qualified;

    // (RULE8) Source selection, code 11 none
    assign pre_level = (pre_source < `CPS_SRC_NONE) ? sources[pre_source[3:0]] : 1'b0;

    // (RULE3) Precondition edge by code
    assign pre_hit = (pre_source < `CPS_SRC_NONE) &&
        (((pre_edge == `CPS_EDGE_RISE || pre_edge == `CPS_EDGE_BOTH) && rise[pre_source[3:0]]) ||
         ((pre_edge == `CPS_EDGE_FALL || pre_edge == `CPS_EDGE_BOTH) && fall[pre_source[3:0]]));

    // (RULE6) Trigger edge with same choices
    assign trig_hit = (trigger_source <= `CPS_SRC_MAX) &&
        (((trigger_edge_select == `CPS_EDGE_RISE || trigger_edge_select == `CPS_EDGE_BOTH) &&
          rise[trigger_source[3:0]]) ||
         ((trigger_edge_select == `CPS_EDGE_FALL || trigger_edge_select == `CPS_EDGE_BOTH) &&
          fall[trigger_source[3:0]]));

    // (RULE5) Trigger edge always, precondition per mode
    // (RULE10) Mode qualification
    // (RULE11) Armed, and the tick holdoff count at zero
    assign qualified = capture_enable && trig_hit && (
        (event_mode_select == `CPS_EV_IGNORE) ||
        (event_mode_select == `CPS_EV_AFTER && armed && hold == 8'h00 && !pre_hit) ||
        (event_mode_select == `CPS_EV_HIGH && pre_level) ||
        (event_mode_select == `CPS_EV_LOW && !pre_level));

    always @* begin
        next_hold = hold;
        if (pre_hit) begin
            next_hold = HOLD_CYC[7:0] - 8'h01;
        end else if (hold != 8'h00) begin
            next_hold = hold - 8'h01;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= {`CPS_NUM_SRC{1'b0}};
            armed <= 1'b0;
            hold <= 8'h00;
            captured_position <= 64'h0000000000000000;
            capture_event <= 1'b0;
        end else begin
            // (RULE12) Previous-cycle sample
            prev <= sources;
            hold <= next_hold;
            capture_event <= qualified;
            if (pre_hit && capture_enable) begin
                armed <= 1'b1;
            end else if (qualified || !capture_enable) begin
                armed <= 1'b0;
            end
            // (RULE1) Store signed position
            if (qualified) begin
                captured_position <= position_units;
            end
        end
    end
endmodule // cps_channel

module cps_capture_precondition_select #(
    parameter CNT16_SHIFT = 16
) (
    input wire ref_clk,
    input wire arst_n,
    input wire [6:0] general_input,
    input wire [2:0] differential_input,
    input wire primary_index,
    input wire tertiary_index,
    input wire [63:0] position_counts,
    input wire linear_axis,
    input wire [7:0] rotary_position_units,
    input wire [7:0] linear_position_units,
    input wire [7:0] trigger_source_ch0,
    input wire [7:0] trigger_source_ch1,
    input wire [7:0] trigger_edge_select_ch0,
    input wire [7:0] trigger_edge_select_ch1,
    input wire [1:0] event_mode_select_ch0,
    input wire [1:0] event_mode_select_ch1,
    input wire capture_enable_ch0,
    input wire capture_enable_ch1,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output wire capture_event_ch0,
    output wire capture_event_ch1
);
    localparam HOLD_CYC = (`CPS_TICK_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS;

    reg [1:0] rst_sync;
    wire rst_n = rst_sync[1];
    wire [`CPS_NUM_SRC-1:0] raw_src = {tertiary_index, primary_index, differential_input, general_input};
    reg [`CPS_NUM_SRC-1:0] sync1;
    reg [`CPS_NUM_SRC-1:0] sync2;
    reg [`CPS_NUM_SRC-1:0] sync3;
    reg [`CPS_NUM_SRC-1:0] src_level;
    reg [7:0] precondition_edge_ch0;
    reg [7:0] precondition_edge_ch1;
    reg [7:0] precondition_filter_ch0;
    reg [7:0] precondition_filter_ch1;
    reg [7:0] precondition_source_ch0;
    reg [7:0] precondition_source_ch1;
    wire [63:0] captured_position_ch0;
    wire [63:0] captured_position_ch1;
    wire [7:0] unit_code = linear_axis ? linear_position_units : rotary_position_units;
    wire [63:0] position_units;
    reg [15:0] next_rdata;

    // (RULE2) Counts converted to the selected unit
    // Both arms signed so the shift keeps the sign
    assign position_units = (unit_code == `CPS_UNIT_CNT16) ?
        ($signed(position_counts) >>> CNT16_SHIFT) : $signed(position_counts);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // Three-stage sync, change taken when the last two stages agree
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= {`CPS_NUM_SRC{1'b0}};
            sync2 <= {`CPS_NUM_SRC{1'b0}};
            sync3 <= {`CPS_NUM_SRC{1'b0}};
            src_level <= {`CPS_NUM_SRC{1'b0}};
        end else begin
            sync1 <= raw_src;
            sync2 <= sync1;
            sync3 <= sync2;
            src_level <= (sync2 & sync3) | (src_level & (sync2 | sync3));
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // (RULE4) Edge resets rising
            precondition_edge_ch0 <= `CPS_EDGE_RST;
            precondition_edge_ch1 <= `CPS_EDGE_RST;
            precondition_filter_ch0 <= `CPS_FILT_RST;
            precondition_filter_ch1 <= `CPS_FILT_RST;
            // (RULE9) Source resets to zero
            precondition_source_ch0 <= `CPS_SRC_RST;
            precondition_source_ch1 <= `CPS_SRC_RST;
        end else if (reg_wr) begin
            // (RULE4) Only 1..3 accepted
            if (reg_addr == `CPS_EDGE_CH0 && reg_wdata[7:0] >= `CPS_EDGE_MIN && reg_wdata[7:0] <= `CPS_EDGE_MAX) begin
                precondition_edge_ch0 <= reg_wdata[7:0];
            end
            if (reg_addr == `CPS_EDGE_CH1 && reg_wdata[7:0] >= `CPS_EDGE_MIN && reg_wdata[7:0] <= `CPS_EDGE_MAX) begin
                precondition_edge_ch1 <= reg_wdata[7:0];
            end
            // (RULE7) Stored only, path unaffected
            if (reg_addr == `CPS_FILT_CH0 && reg_wdata[7:0] <= `CPS_FILT_MAX) begin
                precondition_filter_ch0 <= reg_wdata[7:0];
            end
            if (reg_addr == `CPS_FILT_CH1 && reg_wdata[7:0] <= `CPS_FILT_MAX) begin
                precondition_filter_ch1 <= reg_wdata[7:0];
            end
            // (RULE9) Only 0..11 accepted
            if (reg_addr == `CPS_SRC_CH0 && reg_wdata[7:0] <= `CPS_SRC_MAX) begin
                precondition_source_ch0 <= reg_wdata[7:0];
            end
            if (reg_addr == `CPS_SRC_CH1 && reg_wdata[7:0] <= `CPS_SRC_MAX) begin
                precondition_source_ch1 <= reg_wdata[7:0];
            end
        end
    end

    // Read mux, high word first, unmapped reads zero
    always @* begin
        case (reg_addr)
            `CPS_POS_CH0: next_rdata = captured_position_ch0[63:48];
            `CPS_POS_CH0 + 8'h01: next_rdata = captured_position_ch0[47:32];
            `CPS_POS_CH0 + 8'h02: next_rdata = captured_position_ch0[31:16];
            `CPS_POS_CH0 + 8'h03: next_rdata = captured_position_ch0[15:0];
            `CPS_EDGE_CH0: next_rdata = {8'h00, precondition_edge_ch0};
            `CPS_FILT_CH0: next_rdata = {8'h00, precondition_filter_ch0};
            `CPS_SRC_CH0: next_rdata = {8'h00, precondition_source_ch0};
            `CPS_POS_CH1: next_rdata = captured_position_ch1[63:48];
            `CPS_POS_CH1 + 8'h01: next_rdata = captured_position_ch1[47:32];
            `CPS_POS_CH1 + 8'h02: next_rdata = captured_position_ch1[31:16];
            `CPS_POS_CH1 + 8'h03: next_rdata = captured_position_ch1[15:0];
            `CPS_EDGE_CH1: next_rdata = {8'h00, precondition_edge_ch1};
            `CPS_FILT_CH1: next_rdata = {8'h00, precondition_filter_ch1};
            `CPS_SRC_CH1: next_rdata = {8'h00, precondition_source_ch1};
            default: next_rdata = 16'h0000;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    cps_channel #(.HOLD_CYC(HOLD_CYC)) u_ch0 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sources(src_level),
        .pre_source(precondition_source_ch0),
        .pre_edge(precondition_edge_ch0),
        .trigger_source(trigger_source_ch0),
        .trigger_edge_select(trigger_edge_select_ch0),
        .event_mode_select(event_mode_select_ch0),
        .capture_enable(capture_enable_ch0),
        .position_units(position_units),
        .captured_position(captured_position_ch0),
        .capture_event(capture_event_ch0)
    );

    cps_channel #(.HOLD_CYC(HOLD_CYC)) u_ch1 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sources(src_level),
        .pre_source(precondition_source_ch1),
        .pre_edge(precondition_edge_ch1),
        .trigger_source(trigger_source_ch1),
        .trigger_edge_select(trigger_edge_select_ch1),
        .event_mode_select(event_mode_select_ch1),
        .capture_enable(capture_enable_ch1),
        .position_units(position_units),
        .captured_position(captured_position_ch1),
        .capture_event(capture_event_ch1)
    );
endmodule // cps_capture_precondition_select

`default_nettype wire

// ==== verification/cps_sva.sv ====
/* Checker for the capture block: register reads and capture pulses.
   Bound to the top module; sees its ports only. */
`default_nettype none
module cps_sva (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] trigger_edge_select_ch0,
    input wire logic capture_enable_ch0,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic capture_event_ch0,
    input wire logic capture_event_ch1
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_rd_edge;
        reg_rd && (reg_addr == 8'h44 || reg_addr == 8'h5E);
    endsequence
    sequence s_rd_filt;
        reg_rd && (reg_addr == 8'h46 || reg_addr == 8'h60);
    endsequence
    sequence s_rd_src;
        reg_rd && (reg_addr == 8'h48 || reg_addr == 8'h62);
    endsequence
    a_reset_quiet: assert property ($rose(arst_n) |-> (reg_rdata == 16'h0000 && !capture_event_ch0) [*2])
        else $error("output active after reset");
    a_pulse_ch0: assert property (capture_event_ch0 |=> !capture_event_ch0)
        else $error("capture pulse ch0 too long");
    a_pulse_ch1: assert property (capture_event_ch1 |=> !capture_event_ch1)
        else $error("capture pulse ch1 too long");
    a_capture_enabled: assert property (capture_event_ch0 |-> $past(capture_enable_ch0))
        else $error("capture while disabled");
    a_trigger_code: assert property (capture_event_ch0 |-> $past(trigger_edge_select_ch0) inside {[8'h01:8'h03]})
        else $error("capture with no edge code");
    a_edge_range: assert property (s_rd_edge |=> reg_rdata inside {[16'h0001:16'h0003]})
        else $error("edge setting out of range");
    a_filter_range: assert property (s_rd_filt |=> reg_rdata <= 16'h0002)
        else $error("filter setting out of range");
    a_source_range: assert property (s_rd_src |=> reg_rdata <= 16'h000B)
        else $error("source setting out of range");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
endmodule // cps_sva
bind cps_capture_precondition_select cps_sva u_sva (.ref_clk, .arst_n, .trigger_edge_select_ch0, .capture_enable_ch0,
    .reg_addr, .reg_rd, .reg_rdata, .capture_event_ch0, .capture_event_ch1);
`default_nettype wire

// ==== verification/cps_pin_model.sv ====
/* Input pin model: pin levels follow want after lag clock cycles.
   Assumes want changes on ref_clk. */
`default_nettype none
module cps_pin_model (
    input wire logic ref_clk,
    input wire logic [11:0] want,
    input wire logic [2:0] lag,
    output logic [6:0] general_input,
    output logic [2:0] differential_input,
    output logic primary_index,
    output logic tertiary_index
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] pipe [8] = '{default: 12'h000};
    always @(posedge ref_clk) begin
        pipe[0] <= want;
        for (int i = 1; i < 8; i++) begin
            pipe[i] <= pipe[i - 1];
        end
    end
    assign {tertiary_index, primary_index, differential_input, general_input} = lag == 3'h0 ? want : pipe[lag - 3'h1];
endmodule // cps_pin_model
`default_nettype wire

// ==== verification/cps_capture_precondition_select_test.sv ====
/* Bench for the capture block: register tasks and capture scenarios.
   Assumes the pin model drives the capture inputs. */
`default_nettype none
module cps_capture_precondition_select_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, arst_n = 1'b0, lin = 1'b0, en0 = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, ru = 8'h00, lu = 8'h00, ts0 = 8'h00, te0 = 8'h01;
    logic [1:0] em0 = 2'h0;
    logic [2:0] lag = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [63:0] pos = 64'hFFFF_FFFF_F123_4567;
    logic [11:0] want = 12'h000;
    logic [6:0] general_input;
    logic [2:0] differential_input;
    logic primary_index, tertiary_index, capture_event_ch0, capture_event_ch1;
    int err_count = 0, comparisons = 0, cyc = 0, n0 = 0, n1 = 0, c = 0;
    logic [23:0] rt [9] = '{24'h40_0000, 24'h43_0000, 24'h44_0001, 24'h46_0000, 24'h48_0000, 24'h5A_0000,
        24'h5E_0001, 24'h60_0000, 24'h62_0000};
    logic [39:0] wt [9] = '{40'h44_0003_0003, 40'h44_0000_0003, 40'h44_0004_0003, 40'h46_0002_0002,
        40'h46_0003_0002, 40'h48_000B_000B, 40'h48_000C_000B, 40'h40_1234_0000, 40'h5E_0002_0002};
    cps_pin_model u_pins (.ref_clk, .want, .lag, .general_input, .differential_input, .primary_index, .tertiary_index);
    cps_capture_precondition_select dut (.ref_clk, .arst_n, .general_input, .differential_input, .primary_index,
        .tertiary_index, .position_counts(pos), .linear_axis(lin), .rotary_position_units(ru),
        .linear_position_units(lu), .trigger_source_ch0(ts0), .trigger_source_ch1(8'h00),
        .trigger_edge_select_ch0(te0), .trigger_edge_select_ch1(8'h03), .event_mode_select_ch0(em0),
        .event_mode_select_ch1(2'h0), .capture_enable_ch0(en0), .capture_enable_ch1(1'b1), .reg_addr, .reg_wr,
        .reg_wdata, .reg_rd, .reg_rdata, .capture_event_ch0, .capture_event_ch1);
    initial forever #2.5 ref_clk = ~ref_clk;
    task close_out;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(reg_rdata, e);
    endtask
    task rdpos(input logic [7:0] b, input logic [63:0] v);
        for (int i = 0; i < 4; i++) begin
            rd(b + 8'(i), v[63 - 16 * i -: 16]);
        end
    endtask
    task tog(input int b);
        @(posedge ref_clk);
        want[b] <= ~want[b];
        repeat (20) @(posedge ref_clk);
    endtask
    task pair(input int b, input int e);
        c = n0;
        tog(b);
        tog(11);
        chk(16'(n0 - c), 16'(e));
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (capture_event_ch0 === 1'b1) n0++;
        if (capture_event_ch1 === 1'b1) n1++;
        if (cyc == 6000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        foreach (rt[i]) rd(rt[i][23:16], rt[i][15:0]); // reset values
        foreach (wt[i]) begin
            wr(wt[i][39:32], wt[i][31:16]);
            rd(wt[i][39:32], wt[i][15:0]); // accepted or refused
        end
        en0 <= 1'b1;
        for (int e = 1; e < 4; e++) begin
            te0 <= 8'(e);
            pair(0, int'(e != 2)); // rising trigger
            pair(0, int'(e != 1)); // falling trigger
        end
        rdpos(8'h40, pos); // counts
        rdpos(8'h5A, pos); // second channel
        ru <= 8'h04;
        tog(0);
        rdpos(8'h40, $signed(pos) >>> 16); // coarse units
        lin <= 1'b1;
        pos <= 64'h0123_4567_89AB_CDEF;
        c = n1;
        tog(0);
        chk(16'(n1 - c), 16'h0001); // second channel falling edge, both-edge setting
        rdpos(8'h5A, pos); // linear units
        ts0 <= 8'h0B;
        em0 <= 2'h2;
        for (int k = 0; k < 11; k++) begin
            wr(8'h48, 16'(k));
            pair(k, 1); // selected input high
            pair(k, 0); // selected input low
        end
        em0 <= 2'h3;
        wr(8'h48, 16'h000B);
        pair(0, 1); // unassigned source low
        em0 <= 2'h2;
        pair(0, 0); // high mode blocked
        en0 <= 1'b0;
        em0 <= 2'h1;
        wr(8'h48, 16'h0000);
        en0 <= 1'b1;
        for (int e = 1; e < 4; e++) begin
            wr(8'h44, 16'(e));
            pair(0, int'(e != 2)); // after rising edge
            pair(0, int'(e != 1)); // after falling edge
        end
        lag <= 3'h5;
        c = n0;
        want <= want ^ 12'h801;
        repeat (20) @(posedge ref_clk);
        chk(16'(n0 - c), 16'h0000); // same tick ignored
        pair(2, 1); // later trigger captures
        c = n0;
        want[0] <= ~want[0];
        repeat (3) @(posedge ref_clk);
        want[11] <= ~want[11];
        repeat (20) @(posedge ref_clk);
        chk(16'(n0 - c), 16'h0000); // trigger inside tick ignored
        tog(11);
        chk(16'(n0 - c), 16'h0001); // armed state kept
        close_out();
    end
endmodule // cps_capture_precondition_select_test
`default_nettype wire
